//--- logic/bocu_core.v
// Purpose: Single-bit ops, carry logic, break trap and compare for a 16-bit core
// Assumes: Classic Wishbone slave, one clock, synchronous active-high reset
// Notes: Stack pushes appear in a small internal memory; the break vector is only loaded into PC
`timescale 1ns/1ps
`include "bocu_map.vh"
// Behaviour
// [RULE1] Inverted-OR: carry becomes carry OR not source bit.
// [RULE2] Bit invert complements the addressed destination bit in place.
// [RULE3] Short form also accepts bit addressed by 11-bit base from static base.
// [RULE4] Inverted test loads zero and carry with the complemented source bit.
// [RULE5] Inverted-XOR: carry becomes carry XOR not source bit.
// [RULE6] Bit-OR: carry becomes carry OR source bit.
// [RULE7] Break: SP-2, push PC+1 high and flags, SP-2, push low, load vector.
// [RULE8] Break is taken regardless of interrupt enable or priority level.
// [RULE9] Break saves flags first, then clears U, I and D only.
// [RULE10] Bit set writes one into the destination bit.
// [RULE11] Bit test: zero gets not bit, carry gets the bit.
// [RULE12] Test-and-clear loads zero and carry, then writes zero.
// [RULE13] Test-and-set loads zero and carry, then writes one.
// [RULE14] Bit-XOR: carry becomes carry XOR source bit.
// [RULE15] Compare subtracts source from destination, changing only flags.
// [RULE16] Byte compare into address register zero-extends source to 16 bits.
// [RULE17] Address register as byte-compare source contributes its low 8 bits.
// [RULE18] Bit-writing ops leave flags alone unless carry is the target bit.
module bocu_core
(
  // Clock, reset, enable
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_ce,
  // Wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output wire o_wb_ack,
  output wire o_wb_err,
  // Core-side status
  output wire [15:0] o_flags,
  output wire [15:0] o_sp,
  output wire [19:0] o_pc,
  output wire o_busy
);

localparam ST_IDLE = 3'd0;
localparam ST_PUSH1 = 3'd1;
localparam ST_PUSH2 = 3'd2;
localparam ST_VECT = 3'd3;
localparam ST_DONE = 3'd4;

// Control: [3:0] op, [7:4] bit, [8] byte size, [9] dest addr reg,
// [10] src addr reg, [11] short form, [12] target is carry, [31] go
reg [31:0] ctrl_ff;
reg [15:0] opa_ff;
reg [15:0] opb_ff;
reg [15:0] flags_ff;
reg [15:0] sp_ff;
reg [19:0] pc_ff;
reg [15:0] result_ff;
reg [10:0] sb_ff;
reg [2:0] state_ff;
reg ack_ff;
reg done_ff;
// Stack window indexed by sp[4:1]; not reset, undefined until pushed or written through MEMDAT
reg [15:0] mem_ff [0:15];
reg [3:0] madr_ff;

// Gating by ack_ff keeps a held strobe from being taken in two cycles in a row
wire wb_req = i_wb_cyc & i_wb_stb & ~ack_ff;
wire wb_wr = wb_req & i_wb_we;
wire [3:0] op = ctrl_ff[3:0];
wire [3:0] bsel = ctrl_ff[7:4];
wire is_byte = ctrl_ff[`BOCU_CTL_BYTE];
wire dst_areg = ctrl_ff[`BOCU_CTL_DST_AREG];
wire src_areg = ctrl_ff[`BOCU_CTL_SRC_AREG];
wire short_form = ctrl_ff[`BOCU_CTL_SHORT];
wire tgt_carry = ctrl_ff[`BOCU_CTL_TGT_C];
wire go = ctrl_ff[`BOCU_CTL_GO];
// Wraps within 11 bits, like the short-form base itself
wire [10:0] sb_bitadr = sb_ff + {7'h00, bsel}; // [RULE3]
wire bit_val = opa_ff[bsel];
wire cf = flags_ff[`BOCU_FLG_C];
wire [19:0] pc_next = pc_ff + 20'h00001;
reg adr_ok;
reg [31:0] rd_mux;

// Operand width handling for compare
wire [15:0] cmp_src = (is_byte & src_areg) ? {8'h00, opb_ff[7:0]} : opb_ff; // [RULE17]
wire wide = ~is_byte | dst_areg; // [RULE16]
// Byte into an address register: 16-bit compare against a zero-extended source
wire [15:0] cmp_s = is_byte ? {8'h00, cmp_src[7:0]} : cmp_src; // [RULE16]
wire [15:0] cmp_d = wide ? opa_ff : {8'h00, opa_ff[7:0]};
wire [16:0] diff = {1'b0, cmp_d} - {1'b0, cmp_s}; // [RULE15]
wire [15:0] dres = diff[15:0];
wire msb = wide ? dres[15] : dres[7];
wire zero = wide ? (dres == 16'h0000) : (dres[7:0] == 8'h00);
wire sd = wide ? cmp_d[15] : cmp_d[7];
wire ss = wide ? cmp_s[15] : cmp_s[7];
wire ovf = (sd ^ ss) & (sd ^ msb);
wire nob = ~diff[16];

reg [15:0] nxt_flags;
reg [15:0] nxt_opa;
always @*
begin
  nxt_flags = flags_ff;
  nxt_opa = opa_ff;
  case (op)
    `BOCU_OP_NOR: nxt_flags[`BOCU_FLG_C] = cf | ~bit_val; // [RULE1]
    `BOCU_OP_NXOR: nxt_flags[`BOCU_FLG_C] = cf ^ ~bit_val; // [RULE5]
    `BOCU_OP_OR: nxt_flags[`BOCU_FLG_C] = cf | bit_val; // [RULE6]
    `BOCU_OP_XOR: nxt_flags[`BOCU_FLG_C] = cf ^ bit_val; // [RULE14]
    `BOCU_OP_NTST:
    begin
      nxt_flags[`BOCU_FLG_Z] = ~bit_val; // [RULE4]
      nxt_flags[`BOCU_FLG_C] = ~bit_val; // [RULE4]
    end
    `BOCU_OP_TST:
    begin
      nxt_flags[`BOCU_FLG_Z] = ~bit_val; // [RULE11]
      nxt_flags[`BOCU_FLG_C] = bit_val; // [RULE11]
    end
    `BOCU_OP_TSTC:
    begin
      nxt_flags[`BOCU_FLG_Z] = ~bit_val; // [RULE12]
      nxt_flags[`BOCU_FLG_C] = bit_val;
      nxt_opa[bsel] = 1'b0; // [RULE12]
    end
    `BOCU_OP_TSTS:
    begin
      nxt_flags[`BOCU_FLG_Z] = ~bit_val; // [RULE13]
      nxt_flags[`BOCU_FLG_C] = bit_val;
      nxt_opa[bsel] = 1'b1; // [RULE13]
    end
    `BOCU_OP_INV:
    begin
      nxt_opa[bsel] = ~bit_val; // [RULE2]
      if (tgt_carry)
        nxt_flags[`BOCU_FLG_C] = ~cf; // [RULE18]
    end
    `BOCU_OP_SET:
    begin
      nxt_opa[bsel] = 1'b1; // [RULE10]
      if (tgt_carry)
        nxt_flags[`BOCU_FLG_C] = 1'b1; // [RULE18]
    end
    `BOCU_OP_CLR:
    begin
      nxt_opa[bsel] = 1'b0;
      if (tgt_carry)
        nxt_flags[`BOCU_FLG_C] = 1'b0; // [RULE18]
    end
    `BOCU_OP_CMP:
    begin
      nxt_flags[`BOCU_FLG_O] = ovf; // [RULE15]
      nxt_flags[`BOCU_FLG_S] = msb;
      nxt_flags[`BOCU_FLG_Z] = zero;
      // Carry set means no borrow: destination not below source
      nxt_flags[`BOCU_FLG_C] = nob;
    end
    default:
    begin
      nxt_flags = flags_ff;
      nxt_opa = opa_ff;
    end
  endcase
end

// Read mux and address decode
always @*
begin
  adr_ok = 1'b1;
  rd_mux = 32'h00000000;
  if (i_wb_adr == `BOCU_OFF_CTRL)
    rd_mux = ctrl_ff;
  else if (i_wb_adr == `BOCU_OFF_OPA)
    rd_mux = {16'h0000, opa_ff};
  else if (i_wb_adr == `BOCU_OFF_OPB)
    rd_mux = {5'h00, sb_ff, opb_ff};
  else if (i_wb_adr == `BOCU_OFF_FLAGS)
    rd_mux = {16'h0000, flags_ff};
  else if (i_wb_adr == `BOCU_OFF_SP)
    rd_mux = {16'h0000, sp_ff};
  else if (i_wb_adr == `BOCU_OFF_PC)
    rd_mux = {12'h000, pc_ff};
  else if (i_wb_adr == `BOCU_OFF_RESULT)
    rd_mux = {16'h0000, result_ff};
  else if (i_wb_adr == `BOCU_OFF_STATUS)
    rd_mux = {5'h00, sb_bitadr, 13'h0000, state_ff != ST_IDLE, done_ff, 1'b0};
  else if (i_wb_adr == `BOCU_OFF_MEMADR)
    rd_mux = {28'h0000000, madr_ff};
  else if (i_wb_adr == `BOCU_OFF_MEMDAT)
    rd_mux = {16'h0000, mem_ff[madr_ff]};
  else
    adr_ok = 1'b0;
end

// Unmapped offsets answer with err in place of ack
assign o_wb_ack = ack_ff & adr_ok;
assign o_wb_err = ack_ff & ~adr_ok;
assign o_flags = flags_ff;
assign o_sp = sp_ff;
assign o_pc = pc_ff;
assign o_busy = (state_ff != ST_IDLE);

always @(posedge i_mclk)
begin
  if (i_sys_rst)
  begin
    ctrl_ff <= 32'h00000000;
    opa_ff <= 16'h0000;
    opb_ff <= 16'h0000;
    sb_ff <= 11'h000;
    flags_ff <= `BOCU_RST_FLAGS;
    sp_ff <= `BOCU_RST_SP;
    pc_ff <= `BOCU_RST_PC;
    result_ff <= 16'h0000;
    state_ff <= ST_IDLE;
    ack_ff <= 1'b0;
    done_ff <= 1'b0;
    madr_ff <= 4'h0;
    o_wb_dat <= 32'h00000000;
  end
  else if (i_ce)
  begin
    ack_ff <= wb_req;
    // Read data captured at the taking edge so it stands with ack
    if (wb_req)
      o_wb_dat <= rd_mux;
    // A completion in the same cycle wins over this clear
    if (wb_wr && i_wb_adr == `BOCU_OFF_CTRL && i_wb_sel[0])
      done_ff <= 1'b0;
    // Writes during the trap are acked but dropped, keeping the pushed frame coherent
    if (wb_wr && state_ff == ST_IDLE)
    begin
      if (i_wb_adr == `BOCU_OFF_CTRL)
      begin
        if (i_wb_sel[0]) ctrl_ff[7:0] <= i_wb_dat[7:0];
        if (i_wb_sel[1]) ctrl_ff[15:8] <= i_wb_dat[15:8];
        if (i_wb_sel[3]) ctrl_ff[31] <= i_wb_dat[31];
      end
      else if (i_wb_adr == `BOCU_OFF_OPA)
      begin
        if (i_wb_sel[0]) opa_ff[7:0] <= i_wb_dat[7:0];
        if (i_wb_sel[1]) opa_ff[15:8] <= i_wb_dat[15:8];
      end
      else if (i_wb_adr == `BOCU_OFF_OPB)
      begin
        if (i_wb_sel[0]) opb_ff[7:0] <= i_wb_dat[7:0];
        if (i_wb_sel[1]) opb_ff[15:8] <= i_wb_dat[15:8];
        if (i_wb_sel[2]) sb_ff[7:0] <= i_wb_dat[23:16];
        if (i_wb_sel[3]) sb_ff[10:8] <= i_wb_dat[26:24];
      end
      else if (i_wb_adr == `BOCU_OFF_FLAGS)
      begin
        if (i_wb_sel[0]) flags_ff[7:0] <= i_wb_dat[7:0];
        if (i_wb_sel[1]) flags_ff[15:8] <= i_wb_dat[15:8];
      end
      else if (i_wb_adr == `BOCU_OFF_SP)
      begin
        if (i_wb_sel[0]) sp_ff[7:0] <= i_wb_dat[7:0];
        if (i_wb_sel[1]) sp_ff[15:8] <= i_wb_dat[15:8];
      end
      else if (i_wb_adr == `BOCU_OFF_PC)
      begin
        if (i_wb_sel[0]) pc_ff[7:0] <= i_wb_dat[7:0];
        if (i_wb_sel[1]) pc_ff[15:8] <= i_wb_dat[15:8];
        if (i_wb_sel[2]) pc_ff[19:16] <= i_wb_dat[19:16];
      end
      else if (i_wb_adr == `BOCU_OFF_MEMADR)
      begin
        if (i_wb_sel[0]) madr_ff <= i_wb_dat[3:0];
      end
      else if (i_wb_adr == `BOCU_OFF_MEMDAT)
      begin
        if (i_wb_sel[0]) mem_ff[madr_ff][7:0] <= i_wb_dat[7:0];
        if (i_wb_sel[1]) mem_ff[madr_ff][15:8] <= i_wb_dat[15:8];
      end
    end
    case (state_ff)
      ST_IDLE:
      begin
        if (go)
        begin
          // Go self-clears; a go written on this very edge is lost
          ctrl_ff[`BOCU_CTL_GO] <= 1'b0;
          if (op == `BOCU_OP_BRK)
          begin
            // No mask or priority check: break is nonmaskable
            sp_ff <= sp_ff - `BOCU_SP_STEP; // [RULE7] [RULE8]
            state_ff <= ST_PUSH1;
          end
          else
          begin
            flags_ff <= nxt_flags;
            // Compare leaves the destination untouched
            if (op != `BOCU_OP_CMP)
              opa_ff <= nxt_opa; // [RULE15]
            result_ff <= (op == `BOCU_OP_CMP) ? dres : (short_form ? {5'h00, sb_bitadr} : nxt_opa);
            done_ff <= 1'b1;
          end
        end
      end
      ST_PUSH1:
      begin
        // Flags stored before any of them change
        mem_ff[sp_ff[4:1]] <= {pc_next[19:16], 4'h0, flags_ff[7:0]}; // [RULE7] [RULE9]
        sp_ff <= sp_ff - `BOCU_SP_STEP; // [RULE7]
        state_ff <= ST_PUSH2;
      end
      ST_PUSH2:
      begin
        mem_ff[sp_ff[4:1]] <= pc_next[15:0]; // [RULE7]
        // Clears follow the first push, so the saved copy holds the old flags
        flags_ff[`BOCU_FLG_U] <= 1'b0; // [RULE9]
        flags_ff[`BOCU_FLG_I] <= 1'b0; // [RULE9]
        flags_ff[`BOCU_FLG_D] <= 1'b0; // [RULE9]
        state_ff <= ST_VECT;
      end
      ST_VECT:
      begin
        // Only the vector address is loaded; fetching through it is left to the core
        pc_ff <= `BOCU_BRK_VEC; // [RULE7]
        state_ff <= ST_DONE;
      end
      ST_DONE:
      begin
        // RESULT reports the final stack pointer
        result_ff <= sp_ff;
        done_ff <= 1'b1;
        state_ff <= ST_IDLE;
      end
      default:
        state_ff <= ST_IDLE;
    endcase
  end
end

endmodule

//--- logic/bocu_map.vh
// Purpose: Constants for the bit-operation and compare unit
// Assumes: Included by bocu_core.v only
// Notes: Register offsets are byte addresses, word aligned, on classic Wishbone
`ifndef BOCU_MAP_VH
`define BOCU_MAP_VH
`define BOCU_OFF_CTRL 8'h00
`define BOCU_OFF_OPA 8'h04
`define BOCU_OFF_OPB 8'h08
`define BOCU_OFF_FLAGS 8'h0c
`define BOCU_OFF_SP 8'h10
`define BOCU_OFF_PC 8'h14
`define BOCU_OFF_RESULT 8'h18
`define BOCU_OFF_STATUS 8'h1c
`define BOCU_OFF_MEMADR 8'h20
`define BOCU_OFF_MEMDAT 8'h24
`define BOCU_OP_NOR 4'h0
`define BOCU_OP_INV 4'h1
`define BOCU_OP_NTST 4'h2
`define BOCU_OP_NXOR 4'h3
`define BOCU_OP_OR 4'h4
`define BOCU_OP_BRK 4'h5
`define BOCU_OP_SET 4'h6
`define BOCU_OP_TST 4'h7
`define BOCU_OP_TSTC 4'h8
`define BOCU_OP_TSTS 4'h9
`define BOCU_OP_XOR 4'h0a
`define BOCU_OP_CMP 4'h0b
`define BOCU_OP_CLR 4'h0c
`define BOCU_CTL_BYTE 8
`define BOCU_CTL_DST_AREG 9
`define BOCU_CTL_SRC_AREG 10
`define BOCU_CTL_SHORT 11
`define BOCU_CTL_TGT_C 12
`define BOCU_CTL_GO 31
`define BOCU_FLG_C 0
`define BOCU_FLG_D 1
`define BOCU_FLG_Z 2
`define BOCU_FLG_S 3
`define BOCU_FLG_B 4
`define BOCU_FLG_O 5
`define BOCU_FLG_I 6
`define BOCU_FLG_U 7
`define BOCU_BRK_VEC 20'hfffe4
`define BOCU_SP_STEP 16'h0002
`define BOCU_SB_BASE_W 11
`define BOCU_RST_FLAGS 16'h0000
`define BOCU_RST_SP 16'h0400
`define BOCU_RST_PC 20'h00000
`endif

//--- verification/bocu_core_checker.sv
// Purpose: Port checker for bocu_core
// Assumes: One clock, synchronous active-high reset
// Notes: Trap results are judged against state held just before busy rose
`timescale 1ns/1ps
module bocu_core_checker
(
  // Clock and control
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_ce,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  // Observed outputs
  input wire o_wb_ack,
  input wire o_wb_err,
  input wire [15:0] o_flags,
  input wire [15:0] o_sp,
  input wire [19:0] o_pc,
  input wire o_busy
);
  logic [15:0] idle_sp_ff;
  logic [15:0] idle_flags_ff;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  // Snapshot while idle, so the launching edge still sees pre-trap state
  always @(posedge i_mclk)
  begin
    if (!o_busy)
    begin
      idle_sp_ff <= o_sp;
      idle_flags_ff <= o_flags;
    end
  end
  chk_ack_single: assert property (o_wb_ack && i_ce |=> !o_wb_ack) else $error("ack held too long");
  chk_err_single: assert property (o_wb_err && i_ce |=> !o_wb_err) else $error("err held too long");
  chk_ack_latency: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err && i_ce
    |=> o_wb_ack || o_wb_err) else $error("bus answer late");
  chk_ce_freeze: assert property (!i_ce |=> $stable(o_flags) && $stable(o_sp) && $stable(o_pc))
    else $error("state moved with enable low");
  chk_brk_pc:
    assert property ($fell(o_busy) && !$past(i_sys_rst) |-> o_pc == 20'hfffe4)
      else $error("trap vector not loaded");
  chk_brk_sp:
    assert property ($fell(o_busy) && !$past(i_sys_rst) |-> o_sp == idle_sp_ff - 16'h0004)
      else $error("trap stack pointer wrong");
  chk_brk_flags:
    assert property ($fell(o_busy) && !$past(i_sys_rst) |-> o_flags == (idle_flags_ff & ~16'h00c2))
      else $error("trap flags wrong");
  chk_brk_bound:
    assert property ($rose(o_busy) |-> ##[1:20] !o_busy) else $error("trap never ends");
endmodule
bind bocu_core bocu_core_checker bocu_core_checker_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_ce(i_ce), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_wb_err(o_wb_err),
  .o_flags(o_flags), .o_sp(o_sp), .o_pc(o_pc), .o_busy(o_busy));

//--- verification/tb_top.sv
// Purpose: Self-checking bench for bocu_core
// Assumes: Classic Wishbone, one cycle answer
// Notes: Random operands from a fixed seed
`timescale 1ns/1ps
module tb_top;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [3:0] i_wb_sel = 4'hf;
  logic [31:0] i_wb_dat = 32'h0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack, o_wb_err, o_busy;
  logic [15:0] o_flags, o_sp;
  logic [19:0] o_pc;
  int fail_count = 0;
  int total_checks = 0;
  int seed = 32'ha117;
  logic [31:0] q;
  logic er;
  always #5 i_mclk = ~i_mclk;
  bocu_core bocu_core_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_err(o_wb_err), .o_flags(o_flags), .o_sp(o_sp),
    .o_pc(o_pc), .o_busy(o_busy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do
      @(posedge i_mclk);
    while (o_wb_ack !== 1'b1 && o_wb_err !== 1'b1 && ++n < 100);
    if (n >= 100)
      fail_count++;
    q = o_wb_dat;
    er = o_wb_err;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  function automatic logic [31:0] bexp(input logic [3:0] op, input logic [15:0] a, input logic [3:0] b,
    input logic [15:0] f, input logic tc);
    logic s;
    s = a[b];
    case (op)
      4'h0: f[0] = f[0] | ~s;
      4'h1:
      begin
        a[b] = ~s;
        if (tc)
          f[0] = ~f[0];
      end
      4'h2: {f[2], f[0]} = {~s, ~s};
      4'h3: f[0] = f[0] ^ ~s;
      4'h4: f[0] = f[0] | s;
      4'h6:
      begin
        a[b] = 1'b1;
        if (tc)
          f[0] = 1'b1;
      end
      4'h7: {f[2], f[0]} = {~s, s};
      4'h8: {f[2], f[0], a[b]} = {~s, s, 1'b0};
      4'h9: {f[2], f[0], a[b]} = {~s, s, 1'b1};
      4'ha: f[0] = f[0] ^ s;
      default:
      begin
        a[b] = 1'b0;
        if (tc)
          f[0] = 1'b0;
      end
    endcase
    return {f, a};
  endfunction
  function automatic logic [15:0] cexp(input logic [15:0] d, input logic [15:0] s, input logic [15:0] f,
    input logic bm, input logic da);
    logic [16:0] r;
    // Byte moved to the top so borrow, sign and overflow come out at bit 16 and 15
    if (bm && !da)
      {d, s} = {d[7:0], 8'h0, s[7:0], 8'h0};
    else if (bm)
      s = {8'h0, s[7:0]};
    r = {1'b0, d} - {1'b0, s};
    f[0] = ~r[16];
    f[2] = r[15:0] == 16'h0;
    f[3] = r[15];
    f[5] = (d[15] ^ s[15]) & (d[15] ^ r[15]);
    return f;
  endfunction
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #400000;
    fail_count++;
    conclude();
  end
  initial
  begin
    logic [15:0] a, f, s, t;
    logic [3:0] op, b;
    logic [10:0] sb;
    logic [19:0] p;
    logic [31:0] e;
    repeat (12) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    chk({o_flags, o_sp}, 32'h00000400);
    chk({12'h0, o_pc}, 32'h0);
    for (int k = 0; k < 39; k++)
    begin
      op = 4'(k % 13);
      if (op == 4'h5 || op == 4'hb)
        continue;
      a = 16'($random(seed));
      f = 16'($random(seed)) & 16'h00ff;
      b = (k < 13) ? 4'hf : 4'($random(seed));
      sb = 11'($random(seed));
      e = bexp(op, a, b, f, k[1]);
      wb(1'b1, 8'h04, {16'h0, a});
      wb(1'b1, 8'h0c, {16'h0, f});
      wb(1'b1, 8'h08, {5'h0, sb, 16'h0});
      wb(1'b1, 8'h00, {1'b1, 18'h0, k[1], k[0], 3'h0, b, op});
      // Stall the core a while; nothing may move meanwhile
      @(posedge i_mclk);
      i_ce <= 1'b0;
      repeat (2) @(posedge i_mclk);
      i_ce <= 1'b1;
      wb(1'b0, 8'h04, 32'h0);
      chk(q & 32'hffff, {16'h0, e[15:0]});
      wb(1'b0, 8'h0c, 32'h0);
      chk(q & 32'hffff, {16'h0, e[31:16]});
      wb(1'b0, 8'h1c, 32'h0);
      chk({21'h0, q[26:16]}, {21'h0, sb + {7'h0, b}});
      wb(1'b0, 8'h18, 32'h0);
      chk(q & 32'hffff, k[0] ? {21'h0, sb + {7'h0, b}} : {16'h0, e[15:0]});
    end
    for (int k = 0; k < 12; k++)
    begin
      a = 16'($random(seed));
      s = (k < 4) ? a : 16'($random(seed));
      f = 16'($random(seed)) & 16'h00ff;
      wb(1'b1, 8'h04, {16'h0, a});
      wb(1'b1, 8'h08, {16'h0, s});
      wb(1'b1, 8'h0c, {16'h0, f});
      wb(1'b1, 8'h00, {1'b1, 20'h0, k[2] & k[0] & ~k[1], k[1] & k[0], k[0], 8'h0b});
      wb(1'b0, 8'h04, 32'h0);
      chk(q & 32'hffff, {16'h0, a});
      wb(1'b0, 8'h0c, 32'h0);
      chk(q & 32'hffff, {16'h0, cexp(a, s, f, k[0], k[1] & k[0])});
      wb(1'b0, 8'h18, 32'h0);
      t = k[0] ? ((k[1] ? a : {8'h0, a[7:0]}) - {8'h0, s[7:0]}) : a - s;
      chk(q & 32'hffff, {16'h0, t});
    end
    s = 16'($random(seed)) & 16'hfffe;
    p = 20'($random(seed));
    f = (16'($random(seed)) & 16'h00ff) | 16'h0040;
    wb(1'b1, 8'h10, {16'h0, s});
    wb(1'b1, 8'h14, {12'h0, p});
    wb(1'b1, 8'h0c, {16'h0, f});
    wb(1'b1, 8'h00, 32'h80000005);
    // Write during the trap must be dropped yet answered
    wb(1'b1, 8'h10, 32'h00001234);
    chk({31'h0, er}, 32'h0);
    for (int n = 0; n < 20 && o_busy === 1'b1; n++)
      @(posedge i_mclk);
    chk({12'h0, o_pc}, 32'h000fffe4);
    chk({16'h0, o_sp}, {16'h0, s - 16'h0004});
    chk({16'h0, o_flags}, {16'h0, f & ~16'h00c2});
    p = p + 20'h1;
    t = s - 16'h0002;
    wb(1'b1, 8'h20, {28'h0, t[4:1]});
    wb(1'b0, 8'h24, 32'h0);
    chk(q & 32'hffff, {16'h0, p[19:16], 4'h0, f[7:0]});
    t = s - 16'h0004;
    wb(1'b1, 8'h20, {28'h0, t[4:1]});
    wb(1'b0, 8'h24, 32'h0);
    chk(q & 32'hffff, {16'h0, p[15:0]});
    wb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    conclude();
  end
endmodule
